// >>> dv/gcr_checker.sv
// Purpose: Port-level assertions for the global config bank.
// Assumes: Bound into gcr_global_config; one clock domain.
// Notes: Every watched output is registered, one cycle behind its cause.
`timescale 1ns/1ps
`default_nettype none
module gcr_checker #(
  parameter NUM_OUT = 10
) (
  input wire logic i_core_clk,
  input wire logic i_sys_rst,
  input wire logic i_reg_rd,
  input wire logic o_reg_rvalid,
  input wire logic i_sdo_data,
  input wire logic i_sdo_drive,
  input wire logic o_sdo_out,
  input wire logic o_sdo_oe,
  input wire logic i_rom_map_sel,
  input wire logic o_map_rom,
  input wire logic o_map_eeprom,
  input wire logic o_soft_reset,
  input wire logic o_hard_reset,
  input wire logic o_latch_defaults,
  input wire logic o_boot_start,
  input wire logic [NUM_OUT-1:0] i_per_output_stop,
  input wire logic [4*NUM_OUT-1:0] i_output_stop_source,
  input wire logic [NUM_OUT-1:0] o_output_stop
);
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic [NUM_OUT-1:0] src_one;
  // Outputs that listen to the shared stop bit
  always_comb begin
    for (int k = 0; k < NUM_OUT; k++) begin
      src_one[k] = (i_output_stop_source[4*k +: 4] == 4'h1);
    end
  end
  rvalid_pulse_a: assert property (
    1 |=> o_reg_rvalid == $past(i_reg_rd))
    else $error("read valid not one cycle after strobe");
  sdo_low_a: assert property (
    $past(i_sdo_drive & ~i_sdo_data) |-> o_sdo_oe && !o_sdo_out)
    else $error("serial data low not driven");
  sdo_float_a: assert property (
    !$past(i_sdo_drive) |-> !o_sdo_oe)
    else $error("serial data driven while idle");
  stop_src_a: assert property (
    (o_output_stop & ~$past(src_one)) == '0)
    else $error("stop on output with other source");
  stop_per_a: assert property (
    ($past(src_one & i_per_output_stop) & ~o_output_stop) == '0)
    else $error("per-output stop not honoured");
  rom_prio_a: assert property (
    i_rom_map_sel [*3] |-> o_map_rom && !o_map_eeprom)
    else $error("rom select lost priority");
  soft_noboot_a: assert property (
    o_soft_reset |-> !o_boot_start && !o_latch_defaults)
    else $error("boot or relatch during soft reset");
  boot_after_a: assert property (
    $fell(o_hard_reset) |-> ##[0:2] o_boot_start)
    else $error("no boot after hard reset");
  latch_boot_a: assert property (
    o_latch_defaults == o_boot_start)
    else $error("relatch and boot pulses differ");
endmodule
`default_nettype wire

// >>> dv/gcr_global_config_bench.sv
// Purpose: Self-checking bench for the global config bank.
// Assumes: Host model drives the register port at falling edges.
// Notes: Doubler wait shortened to keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module gcr_global_config_bench;
  logic i_core_clk = 1'b0;
  logic i_sys_rst, i_reset_pin_n, i_rom_map_sel, i_pll_bypass_ctl;
  logic i_reg_wr, i_reg_rd, i_sdo_data, i_sdo_drive;
  logic [11:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata;
  logic [9:0] i_per_output_stop, o_output_stop, o_output_enable;
  logic [39:0] i_output_stop_source;
  logic o_reg_rvalid, o_sdo_out, o_sdo_oe, o_map_eeprom, o_map_rom;
  logic o_soft_reset, o_hard_reset, o_boot_start, o_ring_osc_pd;
  logic o_doubler_enable, o_doubler_from_pin, o_xtal_driver_en;
  logic o_xa_single_en, o_pll_enable;
  logic [2:0] o_input_enable;
  logic [3:0] o_monitor_clk;
  logic [5:0] o_grp_sel_int, o_grp_sel_frac, o_grp_sel_bypass;
  logic [5:0] o_grp_sel_path2;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  gcr_global_config u_dut (.i_core_clk, .i_sys_rst, .i_reset_pin_n,
    .i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd, .o_reg_rdata,
    .o_reg_rvalid, .i_rom_map_sel, .i_pll_bypass_ctl, .i_per_output_stop,
    .i_output_stop_source, .i_sdo_data, .i_sdo_drive, .o_sdo_out,
    .o_sdo_oe, .o_map_eeprom, .o_map_rom, .o_soft_reset, .o_hard_reset,
    .o_latch_defaults(), .o_boot_start, .o_output_stop, .o_ring_osc_pd,
    .o_monitor_clk, .o_doubler_enable, .o_doubler_from_pin,
    .o_xtal_driver_en, .o_xa_single_en, .o_pll_enable, .o_input_enable,
    .o_output_enable, .o_grp_sel_int, .o_grp_sel_frac, .o_grp_sel_bypass,
    .o_grp_sel_path2);
  gcr_host_model #(.DBL_WAIT(50)) u_host (.i_core_clk,
    .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid),
    .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr),
    .o_reg_wdata(i_reg_wdata), .o_reg_rd(i_reg_rd));
  // ----
  // Helpers
  // ----
  always #2 i_core_clk = ~i_core_clk;
  // Hang guard, well above the expected run
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      tally_and_finish;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    chk(16'(d), 16'(e));
  endtask
  // Counts boot pulses over six cycles
  task automatic boots(output int s);
    s = 0;
    repeat (6) begin
      @(negedge i_core_clk);
      s += (o_boot_start === 1'b1);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_reset;
    for (int a = 0; a < 10; a++) begin
      rc(a[11:0], 8'h00);
    end
    u_host.wr(12'h009, 8'hff);
    rc(12'h009, 8'h00);
  endtask
  task automatic t_enables;
    u_host.wr(12'h005, 8'ha5);
    u_host.wr(12'h006, 8'hfe);
    u_host.wr(12'h003, 8'hff);
    u_host.wr(12'h004, 8'hfd);
    rc(12'h006, 8'h02);
    rc(12'h003, 8'h01);
    rc(12'h004, 8'h05);
    chk(16'(o_output_enable), 16'h2a5);
    chk(16'({o_pll_enable, o_input_enable}), 16'hd);
  endtask
  // Every mux code in every field, code 01 with both bypass settings
  task automatic t_mux;
    logic [1:0] k;
    for (int c = 0; c < 5; c++) begin
      k = (c == 4) ? 2'h1 : c[1:0];
      i_pll_bypass_ctl = (c == 4);
      u_host.wr(12'h007, {2'h3, k, k, k});
      u_host.wr(12'h008, {2'h0, k, k, k});
      rc(12'h007, {2'h0, k, k, k});
      chk(16'(o_grp_sel_int), 16'({6{k == 2'h0}}));
      chk(16'(o_grp_sel_frac), 16'({6{c == 1}}));
      chk(16'(o_grp_sel_bypass), 16'({6{c == 4}}));
      chk(16'(o_grp_sel_path2), 16'({6{k == 2'h3}}));
    end
    i_pll_bypass_ctl = 1'b0;
    u_host.wr(12'h007, 8'h24);
    u_host.wr(12'h008, 8'h1b);
    rc(12'h008, 8'h1b);
    chk(16'({o_grp_sel_int, o_grp_sel_frac}), 16'h062);
    chk(16'(o_grp_sel_path2), 16'h08);
  endtask
  task automatic t_xtal;
    logic [1:0] m;
    for (int i = 0; i < 4; i++) begin
      m = i[1:0];
      u_host.wr(12'h002, {6'h3f, m});
      rc(12'h002, {6'h01, m});
      chk(16'({o_doubler_enable, o_xtal_driver_en, o_xa_single_en,
        o_doubler_from_pin}), 16'({1'b1, m == 2'h1, m == 2'h2,
        m == 2'h2}));
    end
    u_host.wr(12'h002, 8'h00);
    rc(12'h002, 8'h00);
    chk(16'({o_doubler_enable, o_xtal_driver_en}), 16'h0);
    chk(16'(o_monitor_clk), 16'h0);
  endtask
  task automatic sdo_sweep(input logic od);
    for (int i = 0; i < 4; i++) begin
      @(negedge i_core_clk);
      {i_sdo_drive, i_sdo_data} = i[1:0];
      @(negedge i_core_clk);
      chk(16'({o_sdo_oe, o_sdo_out & o_sdo_oe}), 16'({i[1] && !(od && i[0]),
        i[1] && i[0] && !od}));
    end
    i_sdo_drive = 1'b0;
  endtask
  task automatic t_stop_sdo;
    for (int k = 0; k < 10; k++) begin
      i_output_stop_source[4*k +: 4] = k[3:0];
    end
    u_host.wr(12'h001, 8'h2a);
    rc(12'h001, 8'h2a);
    chk(16'(o_ring_osc_pd), 16'h1);
    chk(16'(o_output_stop), 16'h002);
    sdo_sweep(1'b1);
    i_per_output_stop = 10'h3ff;
    u_host.wr(12'h001, 8'h00);
    rc(12'h001, 8'h00);
    chk(16'({o_ring_osc_pd, o_output_stop}), 16'h002);
    sdo_sweep(1'b0);
    i_output_stop_source = {10{4'h1}};
    i_per_output_stop = 10'h155;
    repeat (2) @(negedge i_core_clk);
    chk(16'(o_output_stop), 16'h155);
    i_per_output_stop = 10'h000;
  endtask
  task automatic t_bank;
    u_host.wr(12'h000, 8'hff);
    u_host.wr(12'h003, 8'h00);
    rc(12'h000, 8'h80);
    rc(12'h003, 8'h00);
    chk(16'({o_map_eeprom, o_map_rom, o_pll_enable}), 16'h5);
    i_rom_map_sel = 1'b1;
    repeat (3) @(negedge i_core_clk);
    chk(16'({o_map_eeprom, o_map_rom}), 16'h1);
    i_rom_map_sel = 1'b0;
    u_host.wr(12'h000, 8'h00);
    rc(12'h003, 8'h01);
  endtask
  task automatic t_resets;
    int s;
    u_host.wr(12'h001, 8'h80);
    u_host.wr(12'h003, 8'h01);
    rc(12'h001, 8'h80);
    rc(12'h003, 8'h00);
    chk(16'({o_soft_reset, o_hard_reset, o_pll_enable}), 16'h4);
    u_host.wr(12'h001, 8'h00);
    boots(s);
    chk(16'(s), 16'h0);
    u_host.wr(12'h005, 8'h3c);
    u_host.wr(12'h001, 8'h40);
    rc(12'h005, 8'h00);
    chk(16'(o_hard_reset), 16'h1);
    u_host.wr(12'h001, 8'h00);
    boots(s);
    chk(16'(s), 16'h1);
    u_host.wr(12'h004, 8'h07);
    i_reset_pin_n = 1'b0;
    repeat (4) @(negedge i_core_clk);
    chk(16'(o_hard_reset), 16'h1);
    i_reset_pin_n = 1'b1;
    boots(s);
    chk(16'(s), 16'h1);
    rc(12'h004, 8'h00);
  endtask
  // Main sequence
  initial begin
    i_sys_rst = 1'b1;
    i_reset_pin_n = 1'b1;
    i_rom_map_sel = 1'b0;
    i_pll_bypass_ctl = 1'b0;
    i_per_output_stop = 10'h000;
    i_output_stop_source = 40'h0;
    i_sdo_data = 1'b0;
    i_sdo_drive = 1'b0;
    repeat (10) @(negedge i_core_clk);
    i_sys_rst = 1'b0;
    t_reset;
    t_enables;
    t_mux;
    t_xtal;
    t_stop_sdo;
    t_bank;
    t_resets;
    tally_and_finish;
  end
endmodule
bind gcr_global_config gcr_checker #(.NUM_OUT(NUM_OUT)) u_chk (
  .i_core_clk, .i_sys_rst, .i_reg_rd, .o_reg_rvalid, .i_sdo_data,
  .i_sdo_drive, .o_sdo_out, .o_sdo_oe, .i_rom_map_sel, .o_map_rom,
  .o_map_eeprom, .o_soft_reset, .o_hard_reset, .o_latch_defaults,
  .o_boot_start, .i_per_output_stop, .i_output_stop_source,
  .o_output_stop);
`default_nettype wire

// >>> dv/gcr_host_model.sv
// Purpose: Host processor model on the register port.
// Assumes: Read data comes one cycle after the strobe edge.
// Notes: Requests change at falling edges only.
`timescale 1ns/1ps
`default_nettype none
module gcr_host_model #(
  parameter DBL_WAIT = 1250000
) (
  input wire logic i_core_clk,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_rvalid,
  output logic [11:0] o_reg_addr,
  output logic o_reg_wr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_rd
);
  logic dbl_ok = 1'b0;
  // Idle bus at start
  initial begin
    o_reg_addr = 12'h000;
    o_reg_wr = 1'b0;
    o_reg_wdata = 8'h00;
    o_reg_rd = 1'b0;
  end
  // Write; data inverted after release so stale data never looks held
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 12'h002) begin
      v[7:4] = 4'h0;
      if (v[2] && !dbl_ok) begin
        repeat (DBL_WAIT) @(negedge i_core_clk);
        dbl_ok = 1'b1;
      end
    end
    @(negedge i_core_clk);
    o_reg_addr = a;
    o_reg_wdata = v;
    o_reg_wr = 1'b1;
    @(negedge i_core_clk);
    o_reg_wr = 1'b0;
    o_reg_wdata = ~v;
  endtask
  // Read; missing valid returns unknown data
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge i_core_clk);
    o_reg_addr = a;
    o_reg_rd = 1'b1;
    @(negedge i_core_clk);
    o_reg_rd = 1'b0;
    // Valid stands only between the two edges after the strobe
    d = (i_reg_rvalid === 1'b1) ? i_reg_rdata : 8'hxx;
  endtask
endmodule
`default_nettype wire

// >>> hw/gcr_global_config.v
// Purpose: Global configuration register bank of the clock synthesizer.
// Assumes: Processor interface decodes a 12-bit address and gives
//          one-cycle read and write strobes on i_core_clk.
// Notes: Control outputs are registered; read data lands one cycle
//        after the read strobe.
`timescale 1ns/1ps
`default_nettype none
`include "gcr_map.vh"

module gcr_global_config #(
  parameter HAS_EEPROM = 1,
  parameter NUM_OUT = 10,
  parameter NUM_GRP = 6
) (
  input wire i_core_clk,
  input wire i_sys_rst,
  input wire i_reset_pin_n,
  input wire [`GCR_ADDR_W-1:0] i_reg_addr,
  input wire i_reg_wr,
  input wire [7:0] i_reg_wdata,
  input wire i_reg_rd,
  output reg [7:0] o_reg_rdata,
  output reg o_reg_rvalid,
  input wire i_rom_map_sel,
  input wire i_pll_bypass_ctl,
  input wire [NUM_OUT-1:0] i_per_output_stop,
  input wire [4*NUM_OUT-1:0] i_output_stop_source,
  input wire i_sdo_data,
  input wire i_sdo_drive,
  output reg o_sdo_out,
  output reg o_sdo_oe,
  output reg o_map_eeprom,
  output reg o_map_rom,
  output reg o_soft_reset,
  output reg o_hard_reset,
  output reg o_latch_defaults,
  output reg o_boot_start,
  output reg [NUM_OUT-1:0] o_output_stop,
  output reg o_ring_osc_pd,
  output reg [3:0] o_monitor_clk,
  output reg o_doubler_enable,
  output reg o_doubler_from_pin,
  output reg o_xtal_driver_en,
  output reg o_xa_single_en,
  output reg o_pll_enable,
  output reg [2:0] o_input_enable,
  output reg [NUM_OUT-1:0] o_output_enable,
  output reg [NUM_GRP-1:0] o_grp_sel_int,
  output reg [NUM_GRP-1:0] o_grp_sel_frac,
  output reg [NUM_GRP-1:0] o_grp_sel_bypass,
  output reg [NUM_GRP-1:0] o_grp_sel_path2
);

  // ----------------------------------------------------------------
  // Reset pin synchroniser
  // ----------------------------------------------------------------
  reg pin_meta_q;
  reg pin_sync_q;
  wire pin_rst;

  // First stage feeds only the second stage
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else begin
      pin_meta_q <= i_reset_pin_n;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign pin_rst = ~pin_sync_q;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  reg soft_rst_q;
  reg hard_rst_q;
  reg [7:0] bank_sel_q;
  reg [7:0] mcfg1_q;
  reg [7:0] mcfg2_q;
  reg [7:0] pll_en_q;
  reg [7:0] in_en_q;
  reg [7:0] out_en_lo_q;
  reg [7:0] out_en_hi_q;
  reg [7:0] mux1_q;
  reg [7:0] mux2_q;
  reg hard_act_d1_q;
  wire hard_act;
  wire core_rst;
  wire bank_away;
  wire wr_own;
  wire [7:0] wd;

  // Pin or hard bit counts as hard reset; soft bit joins for the bank
  assign hard_act = hard_rst_q | pin_rst;
  assign core_rst = hard_act | soft_rst_q;

  // ROM select wins; EEPROM only on variants that have one
  assign bank_away = i_rom_map_sel |
    (bank_sel_q[`GCR_BIT_EEPROM_SEL] &
    (HAS_EEPROM != 0));

  // Offset 0 is always ours; the rest only when not mapped away
  assign wr_own = i_reg_wr & ~core_rst &
    ((i_reg_addr == `GCR_OFS_BANK_SEL) | ~bank_away);
  assign wd = i_reg_wdata;

  // Reset control bits: soft bit survives soft reset, hard bit survives
  // hard-bit reset but clears the soft bit; the pin or system reset clears both, and an MCFG1 write loads both even during soft or hard-bit reset
  always @(posedge i_core_clk) begin
    if (i_sys_rst || pin_rst) begin
      soft_rst_q <= 1'b0;
      hard_rst_q <= 1'b0;
    end else if (i_reg_wr && i_reg_addr == `GCR_OFS_MCFG1) begin
      soft_rst_q <= wd[`GCR_BIT_SOFT_RST];
      hard_rst_q <= wd[`GCR_BIT_HARD_RST];
    end else if (hard_rst_q) begin
      soft_rst_q <= 1'b0;
    end
  end

  // Configuration registers, held at reset values during any reset.
  // Reserved bits are masked so they never store a one.
  always @(posedge i_core_clk) begin
    if (i_sys_rst || core_rst) begin
      bank_sel_q <= `GCR_RST_VAL;
      mcfg1_q <= `GCR_RST_VAL;
      mcfg2_q <= `GCR_RST_VAL;
      pll_en_q <= `GCR_RST_VAL;
      in_en_q <= `GCR_RST_VAL;
      out_en_lo_q <= `GCR_RST_VAL;
      out_en_hi_q <= `GCR_RST_VAL;
      mux1_q <= `GCR_RST_VAL;
      mux2_q <= `GCR_RST_VAL;
    end else if (wr_own) begin
      case (i_reg_addr)
        `GCR_OFS_BANK_SEL: begin
          bank_sel_q <= wd & `GCR_MASK_BANK_SEL;
        end
        `GCR_OFS_MCFG1: begin
          // Reset bits live in their own flops
          mcfg1_q <= wd & `GCR_MASK_MCFG1 & 8'h3f;
        end
        `GCR_OFS_MCFG2: begin
          mcfg2_q <= wd & `GCR_MASK_MCFG2;
        end
        `GCR_OFS_PLL_EN: begin
          pll_en_q <= wd & `GCR_MASK_PLL_EN;
        end
        `GCR_OFS_IN_EN: begin
          in_en_q <= wd & `GCR_MASK_IN_EN;
        end
        `GCR_OFS_OUT_EN_LO: begin
          out_en_lo_q <= wd & `GCR_MASK_OUT_EN_LO;
        end
        `GCR_OFS_OUT_EN_HI: begin
          out_en_hi_q <= wd & `GCR_MASK_OUT_EN_HI;
        end
        `GCR_OFS_MUX1: begin
          mux1_q <= wd & `GCR_MASK_MUX;
        end
        `GCR_OFS_MUX2: begin
          mux2_q <= wd & `GCR_MASK_MUX;
        end
        default: begin
          bank_sel_q <= bank_sel_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  reg [7:0] rd_mux;

  // Mapped-away offsets read zero here; the other space answers them
  always @* begin
    rd_mux = 8'h00;
    if (i_reg_addr == `GCR_OFS_BANK_SEL || !bank_away) begin
      case (i_reg_addr)
        `GCR_OFS_BANK_SEL: rd_mux = bank_sel_q;
        `GCR_OFS_MCFG1: rd_mux = {soft_rst_q, hard_rst_q, mcfg1_q[5:0]};
        `GCR_OFS_MCFG2: rd_mux = mcfg2_q;
        `GCR_OFS_PLL_EN: rd_mux = pll_en_q;
        `GCR_OFS_IN_EN: rd_mux = in_en_q;
        `GCR_OFS_OUT_EN_LO: rd_mux = out_en_lo_q;
        `GCR_OFS_OUT_EN_HI: rd_mux = out_en_hi_q;
        `GCR_OFS_MUX1: rd_mux = mux1_q;
        `GCR_OFS_MUX2: rd_mux = mux2_q;
        default: rd_mux = 8'h00;
      endcase
    end
  end

  // Read data is captured on the strobe and held until the next read
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencing outputs
  // ----------------------------------------------------------------
  // Straps relatch and boot starts when a hard reset or the system reset ends;
  // a soft reset release never produces these pulses
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      hard_act_d1_q <= 1'b1;
      o_latch_defaults <= 1'b0;
      o_boot_start <= 1'b0;
      o_soft_reset <= 1'b0;
      o_hard_reset <= 1'b0;
    end else begin
      hard_act_d1_q <= hard_act;
      o_latch_defaults <= hard_act_d1_q & ~hard_act;
      o_boot_start <= hard_act_d1_q & ~hard_act;
      o_soft_reset <= soft_rst_q & ~hard_act;
      o_hard_reset <= hard_act;
    end
  end

  // ----------------------------------------------------------------
  // Global decodes
  // ----------------------------------------------------------------
  wire [1:0] xtal_mode;

  assign xtal_mode = mcfg2_q[1:0];

  // Monitor clock bits are only carried through; software keeps them 0
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_map_eeprom <= 1'b0;
      o_map_rom <= 1'b0;
      o_ring_osc_pd <= 1'b0;
      o_monitor_clk <= 4'h0;
      o_doubler_enable <= 1'b0;
      o_doubler_from_pin <= 1'b0;
      o_xtal_driver_en <= 1'b0;
      o_xa_single_en <= 1'b0;
      o_pll_enable <= 1'b0;
      o_input_enable <= 3'h0;
      o_output_enable <= {NUM_OUT{1'b0}};
    end else begin
      o_map_rom <= i_rom_map_sel;
      o_map_eeprom <= bank_away & ~i_rom_map_sel;
      o_ring_osc_pd <= mcfg1_q[`GCR_BIT_RING_OSC_DIS];
      o_monitor_clk <= mcfg2_q[7:4];
      o_doubler_enable <= mcfg2_q[`GCR_BIT_DOUBLER];
      // Doubler taps the pin in single-ended mode, else the driver
      o_doubler_from_pin <= (xtal_mode == `GCR_XTAL_SINGLE);
      // Unused mode 11 leaves the driver and single-ended input powered down
      o_xtal_driver_en <= (xtal_mode == `GCR_XTAL_DRIVER);
      o_xa_single_en <= (xtal_mode == `GCR_XTAL_SINGLE);
      o_pll_enable <= pll_en_q[`GCR_BIT_PLL_EN];
      o_input_enable <= in_en_q[2:0];
      o_output_enable <= {out_en_hi_q[1:0],
                          out_en_lo_q};
    end
  end

  // ----------------------------------------------------------------
  // Serial data pin driver
  // ----------------------------------------------------------------
  // Open-drain mode drives only lows; the pullup gives the high
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_sdo_out <= 1'b0;
      o_sdo_oe <= 1'b0;
    end else if (mcfg1_q[`GCR_BIT_OPEN_DRAIN]) begin
      o_sdo_out <= 1'b0;
      o_sdo_oe <= i_sdo_drive & ~i_sdo_data;
    end else begin
      o_sdo_out <= i_sdo_data;
      o_sdo_oe <= i_sdo_drive;
    end
  end

  // ----------------------------------------------------------------
  // Per-output stop
  // ----------------------------------------------------------------
  genvar k;

  generate
    for (k = 0; k < NUM_OUT; k = k + 1) begin : g_stop
      // Both stop sources act only on outputs whose source is global
      always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
          o_output_stop[k] <= 1'b0;
        end else begin
          o_output_stop[k] <=
            (i_output_stop_source[4*k+3:4*k] == `GCR_STOP_SRC_GLOBAL) &
            (mcfg1_q[`GCR_BIT_STOP] | i_per_output_stop[k]);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output group mux decode
  // ----------------------------------------------------------------
  wire [2*NUM_GRP-1:0] grp_mux;

  // Groups A..C from the first register, D..F from the second
  assign grp_mux = {mux2_q[5:0], mux1_q[5:0]};

  generate
    for (k = 0; k < NUM_GRP; k = k + 1) begin : g_mux
      // Code 10 selects nothing rather than guessing a path
      always @(posedge i_core_clk) begin
        if (i_sys_rst) begin
          o_grp_sel_int[k] <= 1'b0;
          o_grp_sel_frac[k] <= 1'b0;
          o_grp_sel_bypass[k] <= 1'b0;
          o_grp_sel_path2[k] <= 1'b0;
        end else begin
          o_grp_sel_int[k] <=
            (grp_mux[2*k+1:2*k] == `GCR_MUX_INT);
          o_grp_sel_frac[k] <=
            (grp_mux[2*k+1:2*k] == `GCR_MUX_FRAC) &
            ~i_pll_bypass_ctl;
          o_grp_sel_bypass[k] <=
            (grp_mux[2*k+1:2*k] == `GCR_MUX_FRAC) &
            i_pll_bypass_ctl;
          o_grp_sel_path2[k] <=
            (grp_mux[2*k+1:2*k] == `GCR_MUX_PATH2);
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// >>> hw/gcr_map.vh
// Purpose: Constants for the global configuration register bank.
// Assumes: 8-bit registers on a 12-bit device register address.
// Notes: Offsets, field positions, masks, reset values and codes.
//
// What this block does
// - Bank bit 7 maps EEPROM above 0x0
// - ROM select overrides EEPROM bank select
// - Soft reset spares reset bits only; open-drain bit clears
// - Soft reset never relatches straps or boots
// - Hard reset acts as reset pin, boots
// - Global stop ORs per-output stop, source 0001
// - Ring oscillator disable bit powers it down
// - Open-drain bit makes serial data low-only
// - Doubler enable powers doubler up or down
// - Crystal pin mode decodes three modes
// - PLL enable bit 0 enables PLL
// - Input enable bits 2..0 drive inputs 3..1
// - Output enable bits 7..0 drive outputs 8..1
// - Second enable register drives outputs 10, 9
// - Group mux: integer, fractional/bypass, path 2
// - First mux register steers groups A, B, C
// - Second mux bits 5:4 steer group F
// - Second mux steers groups E and D
`ifndef GCR_MAP_VH
`define GCR_MAP_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define GCR_ADDR_W 12
`define GCR_OFS_BANK_SEL 12'h000
`define GCR_OFS_MCFG1 12'h001
`define GCR_OFS_MCFG2 12'h002
`define GCR_OFS_PLL_EN 12'h003
`define GCR_OFS_IN_EN 12'h004
`define GCR_OFS_OUT_EN_LO 12'h005
`define GCR_OFS_OUT_EN_HI 12'h006
`define GCR_OFS_MUX1 12'h007
`define GCR_OFS_MUX2 12'h008

// ----------------------------------------------------------------
// Writable bit masks and reset values
// ----------------------------------------------------------------
`define GCR_MASK_BANK_SEL 8'h80
`define GCR_MASK_MCFG1 8'hea
`define GCR_MASK_MCFG2 8'hf7
`define GCR_MASK_PLL_EN 8'h01
`define GCR_MASK_IN_EN 8'h07
`define GCR_MASK_OUT_EN_LO 8'hff
`define GCR_MASK_OUT_EN_HI 8'h03
`define GCR_MASK_MUX 8'h3f
`define GCR_RST_VAL 8'h00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define GCR_BIT_EEPROM_SEL 7
`define GCR_BIT_SOFT_RST 7
`define GCR_BIT_HARD_RST 6
`define GCR_BIT_STOP 5
`define GCR_BIT_RING_OSC_DIS 3
`define GCR_BIT_OPEN_DRAIN 1
`define GCR_BIT_DOUBLER 2
`define GCR_BIT_PLL_EN 0

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define GCR_STOP_SRC_GLOBAL 4'h1
`define GCR_XTAL_OFF 2'h0
`define GCR_XTAL_DRIVER 2'h1
`define GCR_XTAL_SINGLE 2'h2
`define GCR_MUX_INT 2'h0
`define GCR_MUX_FRAC 2'h1
`define GCR_MUX_PATH2 2'h3

`endif
